// [verilog/cvil_params.svh]
// Constants for the charge voltage and input limit setpoint registers.
// Operation
// [RULE_01] Host writes battery voltage setpoint as a 16-bit word with command 0x15.
// [RULE_02] Voltage setpoints from 1.024 V to 19.200 V in 16 mV steps are accepted.
// [RULE_03] Out-of-range voltage write clears the register and stops charging.
// [RULE_04] Voltage setpoint register reads zero after power-on reset.
// [RULE_05] Voltage field is bits 14..4, bit 4 weighs 16 mV.
// [RULE_06] Host writes adapter current limit as a 16-bit word with command 0x3F.
// [RULE_07] Input limits from 128 mA to 8.064 A in 128 mA steps are accepted.
// [RULE_08] Out-of-range input limit write clears the register and stops charging.
// [RULE_09] Input limit register resets to the 4096 mA value.
// [RULE_10] Host should not program an input limit below 512 mA.
// [RULE_11] Input above limit lowers charge current, down to zero, favouring system load.
// [RULE_12] Fast overload reduces charge; still present after 260 us shuts charger down.
// [RULE_13] After fast-overload shutdown, soft restart when adapter can still supply power.
// [RULE_14] Input limit field is bits 12..7, bit 7 weighs 128 mA.
// [RULE_15] Reads return the last accepted value, or zero after a clear.
`ifndef CVIL_PARAMS_SVH
`define CVIL_PARAMS_SVH
`define CVIL_CMD_VOLT 8'h15
`define CVIL_CMD_ILIM 8'h3F
`define CVIL_VOLT_MASK 16'h7FF0
`define CVIL_ILIM_MASK 16'h1F80
`define CVIL_VOLT_SHIFT 4
`define CVIL_ILIM_SHIFT 7
`define CVIL_VOLT_MIN_MV 32'd1024
`define CVIL_VOLT_MAX_MV 32'd19200
`define CVIL_VOLT_LSB_MV 32'd16
`define CVIL_ILIM_MIN_MA 32'd128
`define CVIL_ILIM_MAX_MA 32'd8064
`define CVIL_ILIM_LSB_MA 32'd128
`define CVIL_VOLT_RESET 16'h0000
`define CVIL_ILIM_RESET 16'h1000
`define CVIL_OVL_DELAY_NS 32'd260000
`define CVIL_CLK_PERIOD_NS 32'd4
`define CVIL_OVL_CYCLES (`CVIL_OVL_DELAY_NS / `CVIL_CLK_PERIOD_NS)
`define CVIL_RESTART_CYCLES 32'd65000
`define CVIL_RAMP_STEP 16'h0080
`endif

// [verilog/cvil_pkg.sv]
// Types shared by the setpoint register block.
package cvil_pkg;
  typedef enum logic [1:0] {
    CVIL_CHARGING,
    CVIL_REDUCED,
    CVIL_SHUTDOWN,
    CVIL_RESTART
  } cvil_ovl_state_type;
endpackage

// [verilog/cvil_range_reg.sv]
// One setpoint register with range check and out-of-range clear.
`timescale 1ns/100ps
`include "cvil_params.svh"
module cvil_range_reg #(
  parameter logic [15:0] RESET_VALUE = 16'h0000,
  parameter logic [15:0] FIELD_MASK = 16'hFFFF,
  parameter logic [15:0] LOW_CODE = 16'h0000,
  parameter logic [15:0] HIGH_CODE = 16'hFFFF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] value,
  output logic range_fault
);
  logic [15:0] next_value;
  logic next_range_fault;
  logic [15:0] masked;

  // Bits outside the field are unused; they are not kept, so reads show zero there.
  always_comb
  begin
    masked = wr_data & FIELD_MASK;
    next_value = value;
    next_range_fault = 1'b0;
    if (wr_en)
    begin
      if ((masked < LOW_CODE) || (masked > HIGH_CODE))
      begin
        next_value = 16'h0000; // [RULE_03] [RULE_08]
        next_range_fault = 1'b1;
      end
      else
      begin
        next_value = masked; // [RULE_02] [RULE_07] [RULE_05] [RULE_14]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      value <= RESET_VALUE; // [RULE_04] [RULE_09]
      range_fault <= 1'b0;
    end
    else
    begin
      value <= next_value;
      range_fault <= next_range_fault;
    end
  end
endmodule

// [verilog/cvil_setpoint_regs.sv]
// Setpoint registers and fast input-overload control of the charge controller.
`timescale 1ns/100ps
`include "cvil_params.svh"
module cvil_setpoint_regs #(
  parameter int OVL_CYCLES = `CVIL_OVL_CYCLES,
  parameter int RESTART_CYCLES = `CVIL_RESTART_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic charge_enable,
  input wire logic [15:0] charge_current_req,
  input wire logic input_over_limit,
  input wire logic fast_input_overload_threshold,
  input wire logic adapter_power_good,
  output logic [15:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic [15:0] volt_setpoint_field,
  output logic [15:0] adapter_limit_field,
  output logic [15:0] charge_current_cmd,
  output logic charging,
  output logic overload_shutdown
);
  import cvil_pkg::*;

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  localparam logic [15:0] VOLT_LO =
    16'((`CVIL_VOLT_MIN_MV / `CVIL_VOLT_LSB_MV) << `CVIL_VOLT_SHIFT);
  localparam logic [15:0] VOLT_HI =
    16'((`CVIL_VOLT_MAX_MV / `CVIL_VOLT_LSB_MV) << `CVIL_VOLT_SHIFT);
  localparam logic [15:0] ILIM_LO =
    16'((`CVIL_ILIM_MIN_MA / `CVIL_ILIM_LSB_MA) << `CVIL_ILIM_SHIFT);
  localparam logic [15:0] ILIM_HI =
    16'((`CVIL_ILIM_MAX_MA / `CVIL_ILIM_LSB_MA) << `CVIL_ILIM_SHIFT);

  logic volt_wr;
  logic ilim_wr;
  logic [15:0] volt_value;
  logic [15:0] ilim_value;
  logic volt_fault;
  logic ilim_fault;

  assign volt_wr = cmd_wr && (cmd_code == `CVIL_CMD_VOLT); // [RULE_01]
  assign ilim_wr = cmd_wr && (cmd_code == `CVIL_CMD_ILIM); // [RULE_06]

  cvil_range_reg #(
    .RESET_VALUE(`CVIL_VOLT_RESET),
    .FIELD_MASK(`CVIL_VOLT_MASK),
    .LOW_CODE(VOLT_LO),
    .HIGH_CODE(VOLT_HI)
  ) u_volt (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(volt_wr),
    .wr_data(cmd_wdata),
    .value(volt_value),
    .range_fault(volt_fault)
  );

  cvil_range_reg #(
    .RESET_VALUE(`CVIL_ILIM_RESET),
    .FIELD_MASK(`CVIL_ILIM_MASK),
    .LOW_CODE(ILIM_LO),
    .HIGH_CODE(ILIM_HI)
  ) u_ilim (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(ilim_wr),
    .wr_data(cmd_wdata),
    .value(ilim_value),
    .range_fault(ilim_fault)
  );

  // ----------------------------------------------------------------------
  // Read port and charge state
  // ----------------------------------------------------------------------
  logic [15:0] next_cmd_rdata;
  logic next_cmd_rvalid;
  logic halted;
  logic next_halted;

  always_comb
  begin
    next_cmd_rvalid = cmd_rd;
    next_cmd_rdata = 16'h0000;
    if (cmd_rd)
    begin
      case (cmd_code)
        `CVIL_CMD_VOLT: next_cmd_rdata = volt_value; // [RULE_15]
        `CVIL_CMD_ILIM: next_cmd_rdata = ilim_value; // [RULE_15]
        default: next_cmd_rdata = 16'h0000;
      endcase
    end
    // A range fault latches charging off until a legal value is written again.
    next_halted = halted;
    if (volt_fault || ilim_fault)
    begin
      next_halted = 1'b1; // [RULE_03] [RULE_08]
    end
    else if (volt_wr || ilim_wr)
    begin
      next_halted = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_rdata <= 16'h0000;
      cmd_rvalid <= 1'b0;
      halted <= 1'b0;
    end
    else
    begin
      cmd_rdata <= next_cmd_rdata;
      cmd_rvalid <= next_cmd_rvalid;
      halted <= next_halted;
    end
  end

  // ----------------------------------------------------------------------
  // Fast overload control
  // ----------------------------------------------------------------------
  cvil_ovl_state_type state;
  cvil_ovl_state_type next_state;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic [15:0] cur;
  logic [15:0] next_cur;
  logic [15:0] next_charge_current_cmd;
  logic next_charging;
  logic next_overload_shutdown;
  logic allowed;

  // Zero voltage or zero limit means no charge, so POR alone never charges.
  assign allowed = charge_enable && !halted && (volt_value != 16'h0000) &&
                   (ilim_value != 16'h0000);

  always_comb
  begin
    next_state = state;
    next_timer = timer;
    next_cur = cur;
    case (state)
      CVIL_CHARGING:
      begin
        next_timer = 32'd0;
        if (input_over_limit && (cur >= `CVIL_RAMP_STEP))
        begin
          next_cur = cur - `CVIL_RAMP_STEP; // [RULE_11]
        end
        else if (input_over_limit)
        begin
          next_cur = 16'h0000; // [RULE_11]
        end
        else if (cur < charge_current_req)
        begin
          next_cur = charge_current_req;
        end
        if (fast_input_overload_threshold)
        begin
          next_state = CVIL_REDUCED; // [RULE_12]
        end
      end
      CVIL_REDUCED:
      begin
        next_cur = {1'b0, cur[15:1]}; // [RULE_12]
        next_timer = timer + 32'd1;
        if (!fast_input_overload_threshold)
        begin
          next_state = CVIL_CHARGING;
        end
        else if (timer >= 32'(OVL_CYCLES - 1))
        begin
          next_state = CVIL_SHUTDOWN; // [RULE_12]
          next_timer = 32'd0;
        end
      end
      CVIL_SHUTDOWN:
      begin
        next_cur = 16'h0000;
        next_timer = timer + 32'd1;
        if (timer >= 32'(RESTART_CYCLES - 1) && adapter_power_good)
        begin
          next_state = CVIL_RESTART; // [RULE_13]
          next_timer = 32'd0;
        end
      end
      CVIL_RESTART:
      begin
        // Soft restart ramps current back in steps rather than jumping.
        if (!adapter_power_good || fast_input_overload_threshold)
        begin
          next_state = CVIL_SHUTDOWN;
          next_cur = 16'h0000;
        end
        else if ((cur + `CVIL_RAMP_STEP) >= charge_current_req)
        begin
          next_cur = charge_current_req; // [RULE_13]
          next_state = CVIL_CHARGING;
        end
        else
        begin
          next_cur = cur + `CVIL_RAMP_STEP; // [RULE_13]
        end
      end
      default:
      begin
        next_state = CVIL_CHARGING;
      end
    endcase
    if (!allowed)
    begin
      next_cur = 16'h0000; // [RULE_03] [RULE_08]
      if (state != CVIL_SHUTDOWN)
      begin
        next_state = CVIL_CHARGING;
      end
    end
    next_charge_current_cmd = next_cur;
    next_charging = allowed && (next_state != CVIL_SHUTDOWN);
    next_overload_shutdown = (next_state == CVIL_SHUTDOWN);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= CVIL_CHARGING;
      timer <= 32'd0;
      cur <= 16'h0000;
      charge_current_cmd <= 16'h0000;
      charging <= 1'b0;
      overload_shutdown <= 1'b0;
      volt_setpoint_field <= `CVIL_VOLT_RESET;
      adapter_limit_field <= `CVIL_ILIM_RESET;
    end
    else
    begin
      state <= next_state;
      timer <= next_timer;
      cur <= next_cur;
      charge_current_cmd <= next_charge_current_cmd;
      charging <= next_charging;
      overload_shutdown <= next_overload_shutdown;
      volt_setpoint_field <= volt_value;
      adapter_limit_field <= ilim_value;
    end
  end
endmodule

// [testbench/cvil_setpoint_props.sv]
// Checker for the setpoint register block.
`timescale 1ns/100ps
module cvil_setpoint_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic fast_input_overload_threshold,
  input wire logic adapter_power_good,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_rvalid,
  input wire logic [15:0] volt_setpoint_field,
  input wire logic [15:0] adapter_limit_field,
  input wire logic charging,
  input wire logic overload_shutdown
);
  logic [15:0] vm, im;
  logic v_ok, i_ok, bad_wr;
  assign vm = cmd_wdata & 16'h7FF0;
  assign im = cmd_wdata & 16'h1F80;
  assign v_ok = vm >= 16'h0400 && vm <= 16'h4B00;
  assign i_ok = im >= 16'h0080;
  assign bad_wr = cmd_wr && ((cmd_code == 8'h15 && !v_ok) || (cmd_code == 8'h3F && !i_ok));
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence volt_wr;
    cmd_wr && cmd_code == 8'h15;
  endsequence
  sequence ilim_wr;
    cmd_wr && cmd_code == 8'h3F;
  endsequence
  volt_store_a: assert property (
    volt_wr ##0 v_ok |=> ##1 volt_setpoint_field == $past(vm, 2)) else $error("volt not stored");
  volt_clear_a: assert property (
    volt_wr ##0 !v_ok |=> ##1 volt_setpoint_field == 16'h0000) else $error("volt not cleared");
  ilim_store_a: assert property (
    ilim_wr ##0 i_ok |=> ##1 adapter_limit_field == $past(im, 2)) else $error("limit not stored");
  ilim_clear_a: assert property (
    ilim_wr ##0 !i_ok |=> ##1 adapter_limit_field == 16'h0000) else $error("limit not cleared");
  fault_stop_a: assert property (
    bad_wr |-> ##2 !charging) else $error("charging after fault");
  read_answer_a: assert property (
    cmd_rd |=> cmd_rvalid) else $error("no read answer");
  valid_pulse_a: assert property (
    !cmd_rd |=> !cmd_rvalid) else $error("stray read valid");
  unknown_read_a: assert property (
    cmd_rd && cmd_code != 8'h15 && cmd_code != 8'h3F |=> cmd_rdata == 16'h0000)
    else $error("bad rdata");
  shut_off_a: assert property (
    overload_shutdown |-> !charging) else $error("charging in shutdown");
  // A restart that loses adapter power falls back into shutdown as well.
  shut_cause_a: assert property (
    $rose(overload_shutdown) |->
    $past(fast_input_overload_threshold) || !$past(adapter_power_good))
    else $error("shutdown uncaused");
endmodule

bind cvil_setpoint_regs cvil_setpoint_props props_u (.clk(clk), .rst_b(rst_b), .cmd_wr(cmd_wr),
  .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
  .fast_input_overload_threshold(fast_input_overload_threshold), .cmd_rvalid(cmd_rvalid),
  .adapter_power_good(adapter_power_good),
  .volt_setpoint_field(volt_setpoint_field), .adapter_limit_field(adapter_limit_field),
  .charging(charging), .overload_shutdown(overload_shutdown));

// [testbench/cvil_host_model.sv]
// Host model that issues decoded word writes and reads.
`timescale 1ns/100ps
module cvil_host_model (
  input wire logic clk,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_rvalid,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata
);
  initial
  begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // Released fields are inverted so a stale word is never taken for a live one.
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(negedge clk);
    cmd_wr = 1'b1;
    cmd_code = code;
    cmd_wdata = data;
    @(negedge clk);
    cmd_wr = 1'b0;
    cmd_code = ~code;
    cmd_wdata = ~data;
  endtask
  task automatic rd(input logic [7:0] code, output logic [15:0] data);
    int n;
    @(negedge clk);
    cmd_rd = 1'b1;
    cmd_code = code;
    @(negedge clk);
    cmd_rd = 1'b0;
    cmd_code = ~code;
    n = 0;
    while (cmd_rvalid !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    // A missing answer hands back the inverted bus so that the compare cannot pass.
    data = (cmd_rvalid === 1'b1) ? cmd_rdata : ~cmd_rdata;
  endtask
endmodule

// [testbench/test_charge_voltage_input_limit_regs.sv]
// Self-checking bench for the setpoint registers and overload control.
`timescale 1ns/100ps
module test_charge_voltage_input_limit_regs;
  logic clk, rst_b, cmd_wr, cmd_rd, cmd_rvalid, charging, overload_shutdown;
  logic charge_enable, input_over_limit, fast_input_overload_threshold, adapter_power_good;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, charge_current_req, cmd_rdata, rdata, charge_current_cmd;
  logic [15:0] volt_setpoint_field, adapter_limit_field, field_seen;
  logic [39:0] tbl [10];
  int bad_count = 0;
  int check_count = 0;
  cvil_setpoint_regs #(.OVL_CYCLES(8), .RESTART_CYCLES(8)) dut_u (.clk, .rst_b, .cmd_wr,
    .cmd_rd, .cmd_code, .cmd_wdata, .charge_enable, .charge_current_req, .input_over_limit,
    .fast_input_overload_threshold, .adapter_power_good, .cmd_rdata, .cmd_rvalid,
    .volt_setpoint_field, .adapter_limit_field, .charge_current_cmd, .charging,
    .overload_shutdown);
  cvil_host_model host_u (.clk, .cmd_rdata, .cmd_rvalid, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // The whole sequence needs under 1000 cycles; this allows five times that.
  initial
  begin
    #20000;
    bad_count++;
    conclude();
  end
  initial
  begin
    // The 128 mA entry only probes the range edge; the limit left in use is 4096 mA.
    tbl = '{40'h15_0400_0400, 40'h15_4B00_4B00, 40'h15_8405_0400, 40'h15_03F0_0000,
      40'h15_4B10_0000, 40'h3F_0080_0080, 40'h3F_FFFF_1F80, 40'h3F_0070_0000,
      40'h15_3130_3130, 40'h3F_1000_1000};
    rst_b = 1'b0;
    charge_enable = 1'b1;
    charge_current_req = 16'h0400;
    input_over_limit = 1'b0;
    fast_input_overload_threshold = 1'b0;
    adapter_power_good = 1'b1;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    check(adapter_limit_field, 16'h1000);
    host_u.rd(8'h15, rdata);
    check(rdata, 16'h0000);
    host_u.rd(8'h3F, rdata);
    check(rdata, 16'h1000);
    check(16'(charging), 16'h0000);
    foreach (tbl[i])
    begin
      host_u.wr(tbl[i][39:32], tbl[i][31:16]);
      host_u.rd(tbl[i][39:32], rdata);
      check(rdata, tbl[i][15:0]);
      field_seen = (tbl[i][39:32] == 8'h3F) ? adapter_limit_field : volt_setpoint_field;
      check(field_seen, tbl[i][15:0]);
    end
    host_u.wr(8'h14, 16'h1234);
    host_u.rd(8'h14, rdata);
    check(rdata, 16'h0000);
    host_u.rd(8'h15, rdata);
    check(rdata, 16'h3130);
    repeat (20) @(negedge clk);
    check(16'(charging), 16'h0001);
    check(charge_current_cmd, 16'h0400);
    host_u.wr(8'h15, 16'h03F0);
    repeat (4) @(negedge clk);
    check(16'(charging), 16'h0000);
    check(charge_current_cmd, 16'h0000);
    host_u.wr(8'h15, 16'h3130);
    host_u.wr(8'h3F, 16'h0070);
    repeat (4) @(negedge clk);
    check(16'(charging), 16'h0000);
    host_u.wr(8'h3F, 16'h1000);
    repeat (20) @(negedge clk);
    check(16'(charging), 16'h0001);
    check(charge_current_cmd, 16'h0400);
    input_over_limit = 1'b1;
    repeat (3) @(negedge clk);
    check(16'(charge_current_cmd < 16'h0400), 16'h0001);
    repeat (20) @(negedge clk);
    check(charge_current_cmd, 16'h0000);
    input_over_limit = 1'b0;
    repeat (20) @(negedge clk);
    check(charge_current_cmd, 16'h0400);
    fast_input_overload_threshold = 1'b1;
    adapter_power_good = 1'b0;
    repeat (3) @(negedge clk);
    check(16'(charge_current_cmd < 16'h0400), 16'h0001);
    repeat (5) @(negedge clk);
    check(16'(overload_shutdown), 16'h0000);
    @(negedge clk);
    check(16'({overload_shutdown, charging}), 16'h0002);
    fast_input_overload_threshold = 1'b0;
    repeat (30) @(negedge clk);
    check(16'(overload_shutdown), 16'h0001);
    adapter_power_good = 1'b1;
    repeat (3) @(negedge clk);
    check(16'(charging && (charge_current_cmd < 16'h0400)), 16'h0001);
    repeat (37) @(negedge clk);
    check(16'({overload_shutdown, charging}), 16'h0001);
    check(charge_current_cmd, 16'h0400);
    conclude();
  end
endmodule
